// >>> design/int_exec_pkg.sv
package int_exec_pkg;

    // Register port map, word offsets on a 4-bit byte address
    localparam logic [3:0]  ADDR_FRAME        = 4'h0;
    localparam logic [3:0]  ADDR_RENAME       = 4'h4;
    localparam logic [3:0]  ADDR_FAULT        = 4'h8;

    // Frame word field positions
    localparam int          FRAME_SOF_LSB     = 0;
    localparam int          FRAME_SOL_LSB     = 8;
    localparam int          FRAME_SOR_LSB     = 16;
    // Rename word field positions
    localparam int          RENAME_GR_LSB     = 0;
    localparam int          RENAME_FR_LSB     = 8;
    localparam int          RENAME_PR_LSB     = 16;
    // Fault word bit positions
    localparam int          FAULT_ILLEGAL_BIT = 0;
    localparam int          FAULT_RESERVED_BIT = 1;
    localparam int          FAULT_SPILL_BIT   = 2;

    // Frame limits and field shifts
    localparam logic [8:0]  MAX_FRAME         = 9'h060;
    localparam int          ROT_SHIFT         = 3;
    localparam logic [7:0]  STACKED_BASE      = 8'h20;

    // Reset values
    localparam logic [6:0]  RST_SIZE          = 7'h00;
    localparam logic [3:0]  RST_SOR           = 4'h0;
    localparam logic [6:0]  RST_RRB           = 7'h00;
    localparam logic [5:0]  RST_RRB_PR        = 6'h00;
    localparam logic [2:0]  RST_FAULT         = 3'h0;

    typedef enum logic [1:0] {
        OP_POINTER_ADD_32   = 2'h0,
        OP_AND              = 2'h1,
        OP_AND_WITH_INVERSE = 2'h2,
        OP_ALLOC            = 2'h3
    } op_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'h1,
        ST_SPILL = 2'h2
    } state_t;

    typedef struct packed {
        logic [63:0] value;
        logic        nat;
    } gr_t;

    typedef struct packed {
        logic        valid;
        op_t         op;
        logic        imm_form;
        logic        qualifying_predicate;
        gr_t         src_a;
        gr_t         src_b;
        logic [13:0] short_immediate;
        logic [7:0]  byte_immediate;
        logic [6:0]  dest;
        logic [6:0]  n_in;
        logic [6:0]  n_loc;
        logic [6:0]  n_out;
        logic [6:0]  n_rot;
    } issue_t;

    typedef struct packed {
        logic [6:0] sof;
        logic [6:0] sol;
        logic [3:0] sor;
    } frame_t;

    typedef struct packed {
        logic [6:0] gr;
        logic [6:0] fr;
        logic [5:0] pr;
    } rename_t;

    typedef struct packed {
        logic       valid;
        logic [6:0] dest;
        gr_t        data;
    } wb_t;

    typedef struct packed {
        logic       illegal;
        logic       reserved;
        logic       spill;
    } fault_t;

    typedef struct packed {
        state_t      state;
        logic        ready;
        frame_t      current_frame_marker;
        rename_t     rename;
        frame_t      pend_frame;
        logic [6:0]  pend_dest;
        logic [63:0] pend_pfs;
        fault_t      sticky;
        fault_t      fault;
        wb_t         wb;
        logic        alat_valid;
        logic [7:0]  alat_delta;
        logic        spill_req;
        logic [7:0]  spill_need;
        logic [31:0] rdata;
    } exec_state_t;

endpackage : int_exec_pkg

// >>> design/int_exec_ptr_logic_frame.sv
`timescale 1ns/10ps

// Functional notes
// - Pointer add zeroes sum bits 63:32
// - Then copies operand bits 31:30 to 62:61
// - First operand register or sign-extended short immediate
// - Result token ORs both operand tokens
// - AND writes bitwise AND, byte immediate form
// - AND-with-inverse ANDs first with inverted second
// - Alloc writes previous state, clears token
// - New frame used by alloc write onward
// - Alloc ignores qualifying predicate
// - Frame sizes from inputs, locals, outputs, rotating
// - Illegal fault on oversize or inconsistent frame
// - Reserved fault changing rotating size with renames
// - Alloc stalls until spills free registers
// - Advanced load table told size change first
module int_exec_ptr_logic_frame (
    // Clock and reset
    input  wire logic                 clk_sys_in,
    input  wire logic                 rst_in,
    // Issue
    input  wire int_exec_pkg::issue_t issue_in,
    input  wire logic [63:0]          prev_state_in,
    output logic                      issue_ready_out,
    // Write-back
    output int_exec_pkg::wb_t         wb_out,
    // Faults, one-cycle pulses
    output int_exec_pkg::fault_t      fault_out,
    // Advanced load table notify
    output logic                      alat_valid_out,
    output logic [7:0]                alat_delta_out,
    // Register stack engine
    input  wire logic [6:0]           free_regs_in,
    input  wire logic                 spill_fault_in,
    output logic                      spill_req_out,
    output logic [7:0]                spill_need_out,
    // Frame marker
    output int_exec_pkg::frame_t      frame_out,
    output int_exec_pkg::rename_t     rename_out,
    // Register port
    input  wire logic [3:0]           reg_addr_in,
    input  wire logic [31:0]          reg_wdata_in,
    input  wire logic                 reg_wr_in,
    input  wire logic                 reg_rd_in,
    output logic [31:0]               reg_rdata_out
);

    ////////////////////////////////////////////////////////////////////////////
    int_exec_pkg::exec_state_t s;
    int_exec_pkg::exec_state_t next_s;

    logic [63:0] opnd_a;
    logic        opnd_a_nat;
    logic [63:0] sum;
    logic [63:0] logic_res;
    logic [8:0]  tmp_sof;
    logic [8:0]  tmp_sol;
    logic [3:0]  tmp_sor;
    logic        bad_frame;
    logic        bad_dest;
    logic        bad_rot;
    logic [7:0]  growth;
    logic        short_of_regs;

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    // Frame size change; two's complement so a shrink reads negative
    function automatic logic [7:0] size_delta(input logic [6:0] new_size,
                                              input logic [6:0] old_size);
        size_delta = 8'(new_size) - 8'(old_size);
    endfunction : size_delta

    // Sign extension of the short immediate
    function automatic logic [63:0] widen_short(input logic [13:0] imm);
        widen_short = {{50{imm[13]}}, imm};
    endfunction : widen_short

    // Sign extension of the byte immediate
    function automatic logic [63:0] widen_byte(input logic [7:0] imm);
        widen_byte = {{56{imm[7]}}, imm};
    endfunction : widen_byte

    // Upper half cleared first, region bits copied in after
    // Carry out of bit 31 is lost to the clear on purpose
    function automatic logic [63:0] pointer_result(input logic [31:0] low,
                                                   input logic [1:0]  region);
        pointer_result        = 64'h0000_0000_0000_0000;
        pointer_result[31:0]  = low;
        pointer_result[62:61] = region;
    endfunction : pointer_result

    // Any rename base away from its reset value
    function automatic logic rename_active(input int_exec_pkg::rename_t rb);
        rename_active = (rb.gr != int_exec_pkg::RST_RRB)
                     || (rb.fr != int_exec_pkg::RST_RRB)
                     || (rb.pr != int_exec_pkg::RST_RRB_PR);
    endfunction : rename_active

    ////////////////////////////////////////////////////////////////////////////
    // Operand selection and arithmetic
    always_comb begin
        if (issue_in.imm_form) begin
            if (issue_in.op == int_exec_pkg::OP_POINTER_ADD_32) begin
                opnd_a = widen_short(issue_in.short_immediate);
            end else begin
                opnd_a = widen_byte(issue_in.byte_immediate);
            end
            opnd_a_nat = 1'b0;
        end else begin
            opnd_a     = issue_in.src_a.value;
            opnd_a_nat = issue_in.src_a.nat;
        end
        sum = opnd_a + issue_in.src_b.value;
        if (issue_in.op == int_exec_pkg::OP_AND_WITH_INVERSE) begin
            logic_res = opnd_a & ~issue_in.src_b.value;
        end else begin
            logic_res = opnd_a & issue_in.src_b.value;
        end
    end

    // Frame sizing, kept at 9 bits so oversize sums are not wrapped
    always_comb begin
        tmp_sof = 9'(issue_in.n_in) + 9'(issue_in.n_loc) + 9'(issue_in.n_out);
        tmp_sol = 9'(issue_in.n_in) + 9'(issue_in.n_loc);
        tmp_sor = issue_in.n_rot[6:int_exec_pkg::ROT_SHIFT];
        bad_frame = (tmp_sof > int_exec_pkg::MAX_FRAME)
                 || (9'(issue_in.n_rot) > tmp_sof)
                 || (tmp_sol > tmp_sof);
        // Register zero is read-only; stacked registers start at the base
        bad_dest = (issue_in.dest == 7'h00)
                || (10'(issue_in.dest) >= 10'(int_exec_pkg::STACKED_BASE) + 10'(tmp_sof));
        bad_rot = (tmp_sor != s.current_frame_marker.sor)
               && rename_active(s.rename);
    end

    // Growth of the pending frame; negative values never need spills
    always_comb begin
        growth        = size_delta(s.pend_frame.sof, s.current_frame_marker.sof);
        short_of_regs = ($signed(growth) > $signed({1'b0, free_regs_in}));
    end

    ////////////////////////////////////////////////////////////////////////////
    // Next-state logic
    always_comb begin
        next_s            = s;
        next_s.wb         = '0;
        next_s.fault      = '0;
        next_s.alat_valid = 1'b0;
        next_s.rdata      = 32'h0000_0000;

        case (s.state)
            int_exec_pkg::ST_IDLE: begin
                if (issue_in.valid && s.ready) begin
                    if (issue_in.op == int_exec_pkg::OP_ALLOC) begin
                        // No predicate test: alloc always runs
                        if (bad_frame || bad_dest) begin
                            next_s.fault.illegal = 1'b1;
                        end else if (bad_rot) begin
                            next_s.fault.reserved = 1'b1;
                        end else begin
                            next_s.pend_frame.sof = tmp_sof[6:0];
                            next_s.pend_frame.sol = tmp_sol[6:0];
                            next_s.pend_frame.sor = tmp_sor;
                            next_s.pend_dest      = issue_in.dest;
                            next_s.pend_pfs       = prev_state_in;
                            // Notify precedes any commit of the marker
                            next_s.alat_valid = 1'b1;
                            next_s.alat_delta = size_delta(tmp_sof[6:0], s.current_frame_marker.sof);
                            next_s.state      = int_exec_pkg::ST_SPILL;
                        end
                    end else if (issue_in.qualifying_predicate) begin
                        next_s.wb.valid = 1'b1;
                        next_s.wb.dest  = issue_in.dest;
                        next_s.wb.data.nat = opnd_a_nat | issue_in.src_b.nat;
                        if (issue_in.op == int_exec_pkg::OP_POINTER_ADD_32) begin
                            next_s.wb.data.value = pointer_result(sum[31:0],
                                                                  issue_in.src_b.value[31:30]);
                        end else begin
                            next_s.wb.data.value = logic_res;
                        end
                    end
                end
            end
            int_exec_pkg::ST_SPILL: begin
                if (spill_fault_in) begin
                    // Frame stays as it was when a spill store faults
                    next_s.fault.spill = 1'b1;
                    next_s.state       = int_exec_pkg::ST_IDLE;
                end else if (!short_of_regs) begin
                    next_s.current_frame_marker = s.pend_frame;
                    next_s.wb.valid      = 1'b1;
                    next_s.wb.dest       = s.pend_dest;
                    next_s.wb.data.value = s.pend_pfs;
                    next_s.wb.data.nat   = 1'b0;
                    next_s.state         = int_exec_pkg::ST_IDLE;
                end
            end
            default: begin
                next_s.state = int_exec_pkg::ST_IDLE;
            end
        endcase

        // Stall: no issue while spills are pending
        next_s.spill_req  = (next_s.state == int_exec_pkg::ST_SPILL);
        next_s.spill_need = (next_s.state == int_exec_pkg::ST_SPILL)
                          ? size_delta(next_s.pend_frame.sof, next_s.current_frame_marker.sof)
                          : 8'h00;
        next_s.ready      = (next_s.state == int_exec_pkg::ST_IDLE);

        // Register writes; an alloc commit in the same cycle wins the frame
        if (reg_wr_in) begin
            case (reg_addr_in)
                int_exec_pkg::ADDR_FRAME: begin
                    if (s.state == int_exec_pkg::ST_IDLE) begin
                        next_s.current_frame_marker.sof = reg_wdata_in[int_exec_pkg::FRAME_SOF_LSB +: 7];
                        next_s.current_frame_marker.sol = reg_wdata_in[int_exec_pkg::FRAME_SOL_LSB +: 7];
                        next_s.current_frame_marker.sor = reg_wdata_in[int_exec_pkg::FRAME_SOR_LSB +: 4];
                    end
                end
                int_exec_pkg::ADDR_RENAME: begin
                    next_s.rename.gr = reg_wdata_in[int_exec_pkg::RENAME_GR_LSB +: 7];
                    next_s.rename.fr = reg_wdata_in[int_exec_pkg::RENAME_FR_LSB +: 7];
                    next_s.rename.pr = reg_wdata_in[int_exec_pkg::RENAME_PR_LSB +: 6];
                end
                int_exec_pkg::ADDR_FAULT: begin
                    if (reg_wdata_in[int_exec_pkg::FAULT_ILLEGAL_BIT]) begin
                        next_s.sticky.illegal = 1'b0;
                    end
                    if (reg_wdata_in[int_exec_pkg::FAULT_RESERVED_BIT]) begin
                        next_s.sticky.reserved = 1'b0;
                    end
                    if (reg_wdata_in[int_exec_pkg::FAULT_SPILL_BIT]) begin
                        next_s.sticky.spill = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // Set after clear so a same-cycle fault is never lost
        next_s.sticky = next_s.sticky | next_s.fault;

        if (reg_rd_in) begin
            case (reg_addr_in)
                int_exec_pkg::ADDR_FRAME: begin
                    next_s.rdata[int_exec_pkg::FRAME_SOF_LSB +: 7] = s.current_frame_marker.sof;
                    next_s.rdata[int_exec_pkg::FRAME_SOL_LSB +: 7] = s.current_frame_marker.sol;
                    next_s.rdata[int_exec_pkg::FRAME_SOR_LSB +: 4] = s.current_frame_marker.sor;
                end
                int_exec_pkg::ADDR_RENAME: begin
                    next_s.rdata[int_exec_pkg::RENAME_GR_LSB +: 7] = s.rename.gr;
                    next_s.rdata[int_exec_pkg::RENAME_FR_LSB +: 7] = s.rename.fr;
                    next_s.rdata[int_exec_pkg::RENAME_PR_LSB +: 6] = s.rename.pr;
                end
                int_exec_pkg::ADDR_FAULT: begin
                    next_s.rdata[int_exec_pkg::FAULT_ILLEGAL_BIT]  = s.sticky.illegal;
                    next_s.rdata[int_exec_pkg::FAULT_RESERVED_BIT] = s.sticky.reserved;
                    next_s.rdata[int_exec_pkg::FAULT_SPILL_BIT]    = s.sticky.spill;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_sys_in or posedge rst_in) begin
        if (rst_in) begin
            s                          <= '0;
            s.state                    <= int_exec_pkg::ST_IDLE;
            s.ready                    <= 1'b1;
            s.current_frame_marker.sof <= int_exec_pkg::RST_SIZE;
            s.current_frame_marker.sol <= int_exec_pkg::RST_SIZE;
            s.current_frame_marker.sor <= int_exec_pkg::RST_SOR;
            s.rename.gr                <= int_exec_pkg::RST_RRB;
            s.rename.fr                <= int_exec_pkg::RST_RRB;
            s.rename.pr                <= int_exec_pkg::RST_RRB_PR;
            s.sticky                   <= int_exec_pkg::RST_FAULT;
        end else begin
            s <= next_s;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        issue_ready_out = s.ready;
        wb_out          = s.wb;
        fault_out       = s.fault;
        alat_valid_out  = s.alat_valid;
        alat_delta_out  = s.alat_delta;
        spill_req_out   = s.spill_req;
        spill_need_out  = s.spill_need;
        frame_out       = s.current_frame_marker;
        rename_out      = s.rename;
        reg_rdata_out   = s.rdata;
    end

endmodule : int_exec_ptr_logic_frame

// >>> tb/int_exec_properties.sv
`timescale 1ns/10ps
module int_exec_properties (
    // Clock and reset
    input wire logic                  clk_sys_in,
    input wire logic                  rst_in,
    // Issue
    input wire int_exec_pkg::issue_t  issue_in,
    input wire logic [63:0]           prev_state_in,
    input wire logic                  issue_ready_out,
    // Results
    input wire int_exec_pkg::wb_t     wb_out,
    input wire int_exec_pkg::fault_t  fault_out,
    input wire logic                  alat_valid_out,
    input wire logic [7:0]            alat_delta_out,
    // Register stack engine
    input wire logic [6:0]            free_regs_in,
    input wire logic                  spill_fault_in,
    input wire logic                  spill_req_out,
    input wire logic [7:0]            spill_need_out,
    // Frame and register port
    input wire int_exec_pkg::frame_t  frame_out,
    input wire int_exec_pkg::rename_t rename_out,
    input wire logic [3:0]            reg_addr_in,
    input wire logic [31:0]           reg_wdata_in,
    input wire logic                  reg_wr_in,
    input wire logic                  reg_rd_in,
    input wire logic [31:0]           reg_rdata_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    // Issue accepted this edge
    wire       go  = issue_in.valid && issue_ready_out;
    wire       alu = go && issue_in.op != int_exec_pkg::OP_ALLOC && issue_in.qualifying_predicate;
    wire [1:0] op  = issue_in.op;

    ptr_upper_a: assert property (alu && op == 2'h0 |=> wb_out.valid && wb_out.data.value[63] == 1'b0 &&
        wb_out.data.value[60:32] == 29'h0) else $error("pointer add upper half not zero");
    ptr_region_a: assert property (alu && op == 2'h0 |=>
        wb_out.data.value[62:61] == $past(issue_in.src_b.value[31:30])) else $error("region bits wrong");
    ptr_sum_a: assert property (alu && op == 2'h0 && !issue_in.imm_form |=> wb_out.data.value[31:0] ==
        $past(issue_in.src_a.value[31:0] + issue_in.src_b.value[31:0])) else $error("pointer sum wrong");
    nat_merge_a: assert property (alu && !issue_in.imm_form |=>
        wb_out.data.nat == $past(issue_in.src_a.nat | issue_in.src_b.nat)) else $error("token merge wrong");
    and_value_a: assert property (alu && op == 2'h1 && !issue_in.imm_form |=>
        wb_out.data.value == $past(issue_in.src_a.value & issue_in.src_b.value)) else $error("and wrong");
    and_inverse_a: assert property (alu && op == 2'h2 && !issue_in.imm_form |=>
        wb_out.data.value == $past(issue_in.src_a.value & ~issue_in.src_b.value)) else $error("andinv wrong");
    pred_block_a: assert property (go && op != 2'h3 && !issue_in.qualifying_predicate |=>
        !wb_out.valid) else $error("write despite zero predicate");
    alat_first_a: assert property (go && op == 2'h3 |=> !wb_out.valid &&
        (alat_valid_out ^ (fault_out.illegal | fault_out.reserved))) else $error("notify missing");
    stall_hold_a: assert property (spill_req_out |-> !issue_ready_out) else $error("ready while stalled");
    frame_bound_a: assert property (frame_out.sof <= 7'h60) else $error("frame above limit");
    spill_commit_a: assert property (spill_req_out && !spill_fault_in &&
        $signed(spill_need_out) <= $signed({1'b0, free_regs_in}) |=> wb_out.valid && !spill_req_out)
        else $error("commit missed with registers free");
    spill_wait_a: assert property (spill_req_out && !spill_fault_in &&
        $signed(spill_need_out) > $signed({1'b0, free_regs_in}) |=> spill_req_out && !wb_out.valid)
        else $error("commit while registers short");

    cover property (alu && op == 2'h0);
    cover property (go && op == 2'h3);
    cover property (spill_req_out [*3]);
    cover property (fault_out.reserved);
endmodule : int_exec_properties

bind int_exec_ptr_logic_frame int_exec_properties chk_i (.clk_sys_in, .rst_in, .issue_in, .prev_state_in,
    .issue_ready_out, .wb_out, .fault_out, .alat_valid_out, .alat_delta_out, .free_regs_in, .spill_fault_in,
    .spill_req_out, .spill_need_out, .frame_out, .rename_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
    .reg_rd_in, .reg_rdata_out);

// >>> tb/int_exec_ptr_logic_frame_tb.sv
`timescale 1ns/10ps
module int_exec_ptr_logic_frame_tb;
    logic                  clk_sys_in = 1'b0;
    logic                  rst_in = 1'b1;
    int_exec_pkg::issue_t  issue_in = '0;
    int_exec_pkg::issue_t  iss;
    logic [63:0]           prev_state_in = '0;
    logic [6:0]            free_regs_in = 7'h7f;
    logic                  spill_fault_in = 1'b0;
    logic [3:0]            reg_addr_in = 4'h0;
    logic [31:0]           reg_wdata_in = 32'h0, reg_rdata_out;
    logic                  reg_wr_in = 1'b0, reg_rd_in = 1'b0;
    logic                  issue_ready_out, alat_valid_out, spill_req_out;
    logic [7:0]            alat_delta_out, spill_need_out;
    int_exec_pkg::wb_t     wb_out;
    int_exec_pkg::fault_t  fault_out;
    int_exec_pkg::frame_t  frame_out;
    int_exec_pkg::rename_t rename_out;
    int                    err_total = 0, check_count = 0, cur_sof = 0, cur_sol = 0, cur_sor = 0, rrb = 0;

    int_exec_ptr_logic_frame uut (.clk_sys_in, .rst_in, .issue_in, .prev_state_in, .issue_ready_out, .wb_out,
        .fault_out, .alat_valid_out, .alat_delta_out, .free_regs_in, .spill_fault_in, .spill_req_out,
        .spill_need_out, .frame_out, .rename_out, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
        .reg_rdata_out);

    initial forever #12.5 clk_sys_in = ~clk_sys_in;

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got %0h exp %0h", $time, got, exp);
        end
    endtask : chk

    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict

    // Reads compare against d; writes send d
    task automatic reg_rw(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= wr;
        reg_rd_in <= !wr;
        @(posedge clk_sys_in);
        reg_wr_in <= 1'b0;
        reg_rd_in <= 1'b0;
        #1;
        if (!wr) chk(reg_rdata_out, d);
    endtask : reg_rw

    task automatic op_task(input int_exec_pkg::op_t op, input logic im, input logic p);
        logic [63:0] a, e;
        iss = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
        iss.valid = 1'b1;
        iss.op = op;
        iss.imm_form = im;
        iss.qualifying_predicate = p;
        a = !im ? iss.src_a.value : op == int_exec_pkg::OP_POINTER_ADD_32 ?
            {{50{iss.short_immediate[13]}}, iss.short_immediate} : {{56{iss.byte_immediate[7]}}, iss.byte_immediate};
        case (op)
            int_exec_pkg::OP_AND: e = a & iss.src_b.value;
            int_exec_pkg::OP_AND_WITH_INVERSE: e = a & ~iss.src_b.value;
            default: e = {1'b0, iss.src_b.value[31:30], 29'h0, a[31:0] + iss.src_b.value[31:0]};
        endcase
        @(posedge clk_sys_in);
        issue_in <= iss;
        @(posedge clk_sys_in);
        issue_in.valid <= 1'b0;
        #1;
        chk(wb_out.valid, p);
        if (p) chk({wb_out.dest, wb_out.data}, {iss.dest, e, !im & iss.src_a.nat | iss.src_b.nat});
    endtask : op_task

    // st: stall cycles before registers free up; sf: spill store faults
    task automatic do_alloc(input int i, l, o, r, d, st, input logic sf);
        int          sof, sol, sor;
        logic        ill, res;
        logic [63:0] pfs;
        sof = i + l + o;
        sol = i + l;
        sor = r >> 3;
        ill = sof > 96 || r > sof || sol > sof || d == 0 || d >= 32 + sof;
        res = !ill && sor != cur_sor && rrb != 0;
        pfs = {$urandom, $urandom};
        iss = {$urandom, $urandom, $urandom, $urandom, $urandom, $urandom};
        iss.valid = 1'b1;
        iss.op = int_exec_pkg::OP_ALLOC;
        iss.qualifying_predicate = 1'b0;
        iss.dest = 7'(d);
        iss.n_in = 7'(i);
        iss.n_loc = 7'(l);
        iss.n_out = 7'(o);
        iss.n_rot = 7'(r);
        @(posedge clk_sys_in);
        issue_in <= iss;
        prev_state_in <= pfs;
        free_regs_in <= st != 0 ? 7'h0 : 7'h7f;
        spill_fault_in <= sf;
        @(posedge clk_sys_in);
        issue_in.valid <= 1'b0;
        #1;
        chk(fault_out, {ill, res, 1'b0});
        if (ill || res) return;
        chk({alat_valid_out, alat_delta_out}, {1'b1, 8'(sof - cur_sof)});
        if (st != 0) chk({spill_req_out, issue_ready_out, spill_need_out}, {2'b10, 8'(sof - cur_sof)});
        // Bounded wait; a lost commit shows as a mismatch below
        for (int n = 0; n < 200 && !wb_out.valid && !fault_out.spill; n++) begin
            @(posedge clk_sys_in);
            if (n == st) free_regs_in <= 7'h7f;
            #1;
        end
        chk(fault_out.spill, sf);
        if (!sf) begin
            chk({wb_out.valid, wb_out.dest, wb_out.data}, {1'b1, 7'(d), pfs, 1'b0});
            cur_sof = sof;
            cur_sol = sol;
            cur_sor = sor;
        end
        chk({frame_out, issue_ready_out}, {7'(cur_sof), 7'(cur_sol), 4'(cur_sor), 1'b1});
    endtask : do_alloc

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h8985));
        repeat (2) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        #1;
        chk({frame_out, rename_out, issue_ready_out}, 1);
        reg_rw(1'b0, int_exec_pkg::ADDR_FRAME, 32'h0);
        reg_rw(1'b0, 4'hc, 32'h0);
        for (int k = 0; k < 30; k++) op_task(int_exec_pkg::op_t'(k % 3), 1'($urandom), k % 5 != 4);
        do_alloc(2, 3, 3, 8, 33, 0, 1'b0);
        reg_rw(1'b0, int_exec_pkg::ADDR_FRAME, 32'h10508);
        do_alloc(40, 40, 17, 8, 33, 0, 1'b0);
        do_alloc(1, 1, 1, 8, 33, 0, 1'b0);
        do_alloc(2, 3, 3, 8, 0, 0, 1'b0);
        do_alloc(2, 3, 3, 8, 40, 0, 1'b0);
        reg_rw(1'b1, int_exec_pkg::ADDR_RENAME, 32'h1);
        rrb = 1;
        #1 chk(rename_out, 20'h02000);
        do_alloc(4, 4, 8, 16, 33, 0, 1'b0);
        do_alloc(4, 4, 8, 8, 33, 0, 1'b0);
        reg_rw(1'b1, int_exec_pkg::ADDR_RENAME, 32'h0);
        rrb = 0;
        reg_rw(1'b0, int_exec_pkg::ADDR_FAULT, 32'h3);
        reg_rw(1'b1, int_exec_pkg::ADDR_FAULT, 32'h7);
        reg_rw(1'b0, int_exec_pkg::ADDR_FAULT, 32'h0);
        do_alloc(8, 8, 8, 8, 33, 3, 1'b0);
        do_alloc(16, 16, 16, 16, 33, 99, 1'b1);
        reg_rw(1'b0, int_exec_pkg::ADDR_FAULT, 32'h4);
        do_alloc(1, 1, 0, 0, 33, 0, 1'b0);
        reg_rw(1'b1, int_exec_pkg::ADDR_FRAME, 32'h10a0c);
        reg_rw(1'b0, int_exec_pkg::ADDR_FRAME, 32'h10a0c);
        give_verdict;
    end

    // Whole run needs well under 2000 cycles
    initial begin
        #(25 * 20000);
        err_total++;
        give_verdict;
    end
endmodule : int_exec_ptr_logic_frame_tb
